//--- core/efb_block.sv
// One flash array block with its own controller, parallel port and serial programming path
// Notes on behaviour
// R1 - Device holds one to four such blocks, each two megabits; instantiate this once each.
// R2 - Every block has its own controller; instances share nothing.
// R3 - Pages of 128 bytes, 33 pages per sector, 64 sectors per block.
// R4 - User partitions start and end on page boundaries; the user keeps to this.
// R5 - Random read within 60 ns, read-ahead hit within 10 ns, no wait states; here 2 and 1 clocks of 40 ns, with ready low meanwhile.
// R6 - Parallel port is 8, 16 or 32 bits wide; cascading is done outside.
// R7 - Page buffer holds the page being modified, eight data blocks.
// R8 - Block buffer keeps the last 128-bit block read for later hits.
// R9 - Check bits stored per block; single errors corrected, double errors detected.
// R10 - Serial path takes an encrypted stream, decrypts it, programs the block.
// R11 - Whole block or per-sector protection refuses writes, commits and serial programs.
// R12 - Read and write control runs on one internal reference clock.
// R13 - Uncorrectable read error flagged beside the returned data.
module efb_block #(
  parameter logic [127:0] DECRYPT_KEY = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [1:0] port_width,
  input wire logic req_valid,
  input wire efb_pkg::efb_req_s req,
  output logic req_ready,
  output logic rsp_valid,
  output efb_pkg::efb_rsp_s rsp,
  input wire logic prot_all,
  input wire logic [efb_pkg::SECTORS-1:0] prot_sector,
  input wire logic sp_sel,
  input wire logic sp_sclk,
  input wire logic sp_sdi,
  output logic ser_done,
  output logic ser_fault
);
  typedef struct packed {
    efb_pkg::efb_state_e st;
    logic [3:0] cnt;
    logic hit;
    efb_pkg::efb_req_s req;
    logic [1:0] wid;
    logic err;
    logic corr;
    logic ready;
    logic rsp_valid;
    efb_pkg::efb_rsp_s rsp;
    logic pb_valid;
    logic pb_dirty;
    logic [efb_pkg::PAGE_W-1:0] pb_page;
    logic [efb_pkg::PB_BITS-1:0] pb;
    logic bb_valid;
    logic [efb_pkg::DBLK_W-1:0] bb_idx;
    logic [efb_pkg::DBLK_BITS-1:0] bb;
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] filt;
    logic [7:0] sh;
    logic [2:0] bitc;
    logic [4:0] bytec;
    logic [efb_pkg::DBLK_W-1:0] ser_addr;
    logic [efb_pkg::DBLK_BITS-1:0] ser_data;
    logic ser_pend;
    logic ser_done;
    logic ser_fault;
  } efb_block_s;

  efb_block_s q;
  efb_block_s d;
  logic [efb_pkg::DBLK_W-1:0] rd_addr;
  logic [efb_pkg::DBLK_W-1:0] wr_addr;
  logic wr_en;
  logic [efb_pkg::DBLK_BITS-1:0] enc_in;
  logic [efb_pkg::CODE_W-1:0] enc_code;
  logic [efb_pkg::CODE_W-1:0] mem_q;
  logic [efb_pkg::DBLK_BITS-1:0] dec_data;
  logic dec_corr;
  logic dec_dbl;
  // Array plus check bits; not reset, contents are nonvolatile
  logic [efb_pkg::CODE_W-1:0] mem [efb_pkg::NUM_DBLK];

  function automatic logic [3:0] align(input logic [3:0] off, input logic [1:0] wid);
    case (wid)
      efb_pkg::WID_X8: align = off;
      efb_pkg::WID_X16: align = {off[3:1], 1'b0};
      default: align = {off[3:2], 2'h0};
    endcase
  endfunction : align

  function automatic logic [31:0] pick(input logic [127:0] blk, input logic [3:0] off,
                                       input logic [1:0] wid);
    logic [127:0] sh;
    sh = blk >> {align(off, wid), 3'h0};
    case (wid)
      efb_pkg::WID_X8: pick = {24'h000000, sh[7:0]};
      efb_pkg::WID_X16: pick = {16'h0000, sh[15:0]};
      default: pick = sh[31:0];
    endcase
  endfunction : pick

  function automatic logic [efb_pkg::PB_BITS-1:0] merge(input logic [efb_pkg::PB_BITS-1:0] pb,
      input logic [6:0] boff, input logic [31:0] wd, input logic [1:0] wid);
    logic [efb_pkg::PB_BITS-1:0] r;
    int n;
    int base;
    r = pb;
    n = (wid == efb_pkg::WID_X8) ? 1 : (wid == efb_pkg::WID_X16) ? 2 : 4;
    base = int'({boff[6:4], align(boff[3:0], wid)});
    for (int j = 0; j < 4; j++) begin
      if (j < n) begin
        r[(base + j) * 8 +: 8] = wd[j * 8 +: 8];
      end
    end
    merge = r;
  endfunction : merge

  function automatic logic locked(input logic [efb_pkg::PAGE_W-1:0] page, input logic all,
                                  input logic [efb_pkg::SECTORS-1:0] sec);
    int s;
    s = int'(page) / efb_pkg::PAGES_PER_SECTOR;
    locked = all | ((s < efb_pkg::SECTORS) ? sec[s] : 1'b1);
  endfunction : locked

  always_comb begin
    logic [efb_pkg::PAGE_W-1:0] page;
    logic [efb_pkg::DBLK_BITS-1:0] blk;
    int idx;
    page = req.addr[efb_pkg::ADDR_W-1:efb_pkg::PAGE_LSB]; // [R3]
    blk = '0;
    idx = 0;
    d = q;
    d.rsp_valid = 1'b0;
    d.ser_done = 1'b0;
    d.ser_fault = 1'b0;
    rd_addr = q.req.addr[efb_pkg::ADDR_W-1:efb_pkg::BOFF_LSB];
    wr_en = 1'b0;
    wr_addr = q.ser_addr;
    enc_in = q.ser_data;

    // Pins from the test port: three flops, filtered value moves when stages 2 and 3 agree
    d.s1 = {sp_sel, sp_sclk, sp_sdi};
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < 3; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.filt[i] = q.s3[i];
      end
    end
    if (!d.filt[2]) begin
      d.bitc = 3'h0;
      d.bytec = 5'h00;
    end else if (d.filt[1] && !q.filt[1]) begin
      d.sh = {q.sh[6:0], d.filt[0]};
      d.bitc = q.bitc + 3'h1;
      if (q.bitc == 3'h7) begin
        if (q.bytec < efb_pkg::REC_ADDR_BYTES) begin
          d.ser_addr = {q.ser_addr[6:0], d.sh};
        end else begin
          idx = int'(q.bytec - efb_pkg::REC_ADDR_BYTES);
          d.ser_data[idx * 8 +: 8] = d.sh ^ DECRYPT_KEY[idx * 8 +: 8]; // [R10]
        end
        d.bytec = (q.bytec == efb_pkg::REC_LAST_BYTE) ? 5'h00 : q.bytec + 5'h01;
        if (q.bytec == efb_pkg::REC_LAST_BYTE) begin
          d.ser_pend = 1'b1;
        end
      end
    end

    case (q.st)
      efb_pkg::EFB_IDLE: begin
        if (q.ser_pend) begin
          d.ser_pend = 1'b0;
          if (int'(q.ser_addr) >= efb_pkg::NUM_DBLK ||
              locked(q.ser_addr[efb_pkg::DBLK_W-1:3], prot_all, prot_sector)) begin
            d.ser_fault = 1'b1; // [R11]
          end else begin
            wr_en = 1'b1; // [R10]
            d.ser_done = 1'b1;
            if (q.bb_idx == q.ser_addr) begin
              d.bb_valid = 1'b0;
            end
            if (q.pb_valid && q.pb_page == q.ser_addr[efb_pkg::DBLK_W-1:3]) begin
              d.pb[int'(q.ser_addr[2:0]) * efb_pkg::DBLK_BITS +: efb_pkg::DBLK_BITS] = q.ser_data;
            end
          end
        end else if (req_valid && q.ready) begin
          d.req = req;
          d.wid = port_width; // [R6]
          d.rsp = '0;
          d.err = 1'b0;
          d.corr = 1'b0;
          d.cnt = 4'h0;
          if (req.commit) begin
            if (!q.pb_dirty) begin
              d.rsp_valid = 1'b1;
            end else if (locked(q.pb_page, prot_all, prot_sector)) begin
              d.rsp_valid = 1'b1; // [R11]
              d.rsp.err = 1'b1;
            end else begin
              d.st = efb_pkg::EFB_PROG;
            end
          end else if (int'(page) >= efb_pkg::NUM_PAGES) begin
            d.rsp_valid = 1'b1;
            d.rsp.err = 1'b1;
          end else if (req.write) begin
            if (locked(page, prot_all, prot_sector)) begin
              d.rsp_valid = 1'b1; // [R11]
              d.rsp.err = 1'b1;
            end else if (q.pb_valid && q.pb_page == page) begin
              d.pb = merge(q.pb, req.addr[6:0], req.wdata, port_width); // [R7]
              d.pb_dirty = 1'b1;
              d.rsp_valid = 1'b1;
            end else if (q.pb_dirty) begin
              // Unsaved edits of another page are never dropped silently
              d.rsp_valid = 1'b1;
              d.rsp.err = 1'b1;
            end else begin
              d.pb_valid = 1'b0;
              d.pb_page = page;
              d.st = efb_pkg::EFB_LOAD;
            end
          end else begin
            d.hit = q.bb_valid && q.bb_idx == req.addr[efb_pkg::ADDR_W-1:efb_pkg::BOFF_LSB]; // [R8]
            d.cnt = d.hit ? 4'(efb_pkg::AHEAD_CYC - 1) : 4'(efb_pkg::RAND_CYC - 1); // [R5]
            d.st = efb_pkg::EFB_ARR;
          end
        end
      end
      efb_pkg::EFB_ARR: begin
        if (q.cnt != 4'h0) begin
          d.cnt = q.cnt - 4'h1;
        end else begin
          blk = q.hit ? q.bb : dec_data; // [R8]
          d.rsp.rdata = pick(blk, q.req.addr[3:0], q.wid); // [R6]
          d.rsp.err = !q.hit && dec_dbl; // [R13]
          d.rsp.corr = !q.hit && dec_corr; // [R9]
          d.rsp_valid = 1'b1;
          d.st = efb_pkg::EFB_IDLE;
          if (!q.hit && !dec_dbl) begin
            d.bb_valid = 1'b1;
            d.bb_idx = q.req.addr[efb_pkg::ADDR_W-1:efb_pkg::BOFF_LSB];
            d.bb = dec_data;
          end
        end
      end
      efb_pkg::EFB_LOAD: begin
        // Two cycles per block: array read, then corrected capture
        rd_addr = {q.pb_page, q.cnt[3:1]};
        d.cnt = q.cnt + 4'h1;
        if (q.cnt[0]) begin
          d.pb[int'(q.cnt[3:1]) * efb_pkg::DBLK_BITS +: efb_pkg::DBLK_BITS] = dec_data; // [R7]
          d.err = q.err | dec_dbl; // [R9]
          d.corr = q.corr | dec_corr;
        end
        if (q.cnt == 4'hF) begin
          d.pb = merge(d.pb, q.req.addr[6:0], q.req.wdata, q.wid);
          d.pb_valid = 1'b1;
          d.pb_dirty = 1'b1;
          d.rsp.err = d.err; // [R13]
          d.rsp.corr = d.corr;
          d.rsp_valid = 1'b1;
          d.st = efb_pkg::EFB_IDLE;
        end
      end
      efb_pkg::EFB_PROG: begin
        wr_en = 1'b1;
        wr_addr = {q.pb_page, q.cnt[2:0]};
        enc_in = q.pb[int'(q.cnt[2:0]) * efb_pkg::DBLK_BITS +: efb_pkg::DBLK_BITS]; // [R7]
        if (q.bb_idx == wr_addr) begin
          d.bb_valid = 1'b0;
        end
        d.cnt = q.cnt + 4'h1;
        if (q.cnt[2:0] == 3'h7) begin
          d.pb_dirty = 1'b0;
          d.rsp_valid = 1'b1;
          d.st = efb_pkg::EFB_IDLE;
        end
      end
      default: begin
        d.st = efb_pkg::EFB_IDLE;
      end
    endcase
    d.ready = (d.st == efb_pkg::EFB_IDLE) && !d.ser_pend;
  end

  // Own controller and array per instance, no shared state [R1] [R2]
  always_ff @(posedge core_clk or posedge rst) begin // [R12]
    if (rst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (ce) begin
      if (wr_en) begin
        mem[wr_addr] <= enc_code; // [R9]
      end
      mem_q <= mem[rd_addr];
    end
  end

  efb_secded #(.DW(efb_pkg::DBLK_BITS), .PW(efb_pkg::CHK_W)) u_enc (
    .enc_data(enc_in),
    .enc_code(enc_code),
    .dec_code('0),
    .dec_data(),
    .dec_corr(),
    .dec_dbl()
  );

  efb_secded #(.DW(efb_pkg::DBLK_BITS), .PW(efb_pkg::CHK_W)) u_dec (
    .enc_data('0),
    .enc_code(),
    .dec_code(mem_q),
    .dec_data(dec_data),
    .dec_corr(dec_corr),
    .dec_dbl(dec_dbl)
  );

  assign req_ready = q.ready;
  assign rsp_valid = q.rsp_valid;
  assign rsp = q.rsp;
  assign ser_done = q.ser_done;
  assign ser_fault = q.ser_fault;
endmodule : efb_block

//--- core/efb_secded.sv
// Single-correct double-detect code over one data block
module efb_secded #(
  parameter int DW = 128,
  parameter int PW = 8
) (
  input wire logic [DW-1:0] enc_data,
  output logic [DW+PW:0] enc_code,
  input wire logic [DW+PW:0] dec_code,
  output logic [DW-1:0] dec_data,
  output logic dec_corr,
  output logic dec_dbl
);
  localparam int NW = DW + PW;

  // Bit 0 is overall parity, bit p is Hamming position p
  always_comb begin
    int k;
    k = 0;
    enc_code = '0;
    for (int p = 1; p <= NW; p++) begin
      if ((p & (p - 1)) != 0) begin
        enc_code[p] = enc_data[k];
        k++;
      end
    end
    for (int i = 0; i < PW; i++) begin
      for (int p = 1; p <= NW; p++) begin
        if (((p >> i) & 1) == 1 && p != (1 << i)) begin
          enc_code[1 << i] = enc_code[1 << i] ^ enc_code[p];
        end
      end
    end
    enc_code[0] = ^enc_code[NW:1];
  end

  always_comb begin
    logic [PW-1:0] syn;
    logic [NW:0] fix;
    int k;
    syn = '0;
    k = 0;
    fix = dec_code;
    dec_data = '0;
    dec_corr = 1'b0;
    dec_dbl = 1'b0;
    for (int i = 0; i < PW; i++) begin
      for (int p = 1; p <= NW; p++) begin
        if (((p >> i) & 1) == 1) begin
          syn[i] = syn[i] ^ dec_code[p];
        end
      end
    end
    if (^dec_code) begin
      if (int'(syn) <= NW) begin
        dec_corr = 1'b1;
        fix[syn] = ~fix[syn];
      end else begin
        dec_dbl = 1'b1;
      end
    end else if (syn != '0) begin
      dec_dbl = 1'b1;
    end
    for (int p = 1; p <= NW; p++) begin
      if ((p & (p - 1)) != 0) begin
        dec_data[k] = fix[p];
        k++;
      end
    end
  end
endmodule : efb_secded

//--- include/efb_pkg.sv
// Constants and carrier types for the embedded flash block
package efb_pkg;
  localparam int PAGE_BYTES = 128;
  localparam int BLK_PER_PAGE = 8;
  localparam int PAGES_PER_SECTOR = 33;
  localparam int SECTORS = 64;
  localparam int DBLK_BITS = 128;
  localparam int NUM_PAGES = PAGES_PER_SECTOR * SECTORS;
  localparam int NUM_DBLK = NUM_PAGES * BLK_PER_PAGE;
  localparam int ADDR_W = 19;
  localparam int PAGE_W = 12;
  localparam int DBLK_W = 15;
  localparam int BOFF_LSB = 4;
  localparam int PAGE_LSB = 7;
  localparam int CHK_W = 8;
  localparam int CODE_W = DBLK_BITS + CHK_W + 1;
  localparam int PB_BITS = PAGE_BYTES * 8;
  localparam int CLK_PERIOD_NS = 40;
  localparam int T_RAND_NS = 60;
  localparam int T_AHEAD_NS = 10;
  localparam int RAND_RAW = (T_RAND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int AHEAD_RAW = (T_AHEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // A miss needs one edge for the array read and one for the answer
  localparam int RAND_CYC = (RAND_RAW < 2) ? 2 : RAND_RAW;
  localparam int AHEAD_CYC = (AHEAD_RAW < 1) ? 1 : AHEAD_RAW;
  localparam logic [1:0] WID_X8 = 2'h0;
  localparam logic [1:0] WID_X16 = 2'h1;
  localparam logic [1:0] WID_X32 = 2'h2;
  localparam logic [4:0] REC_ADDR_BYTES = 5'h02;
  localparam logic [4:0] REC_LAST_BYTE = 5'h11;
  localparam logic [PAGE_W-1:0] PB_PAGE_RESET = 12'h000;

  typedef struct packed {
    logic write;
    logic commit;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } efb_req_s;

  typedef struct packed {
    logic [31:0] rdata;
    logic err;
    logic corr;
  } efb_rsp_s;

  typedef enum logic [1:0] {EFB_IDLE, EFB_ARR, EFB_LOAD, EFB_PROG} efb_state_e;
endpackage : efb_pkg

//--- verif/efb_block_sva.sv
// Port-level checks for one flash block
module efb_block_sva (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [1:0] port_width,
  input wire logic req_valid,
  input wire efb_pkg::efb_req_s req,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire efb_pkg::efb_rsp_s rsp,
  input wire logic prot_all,
  input wire logic ser_done,
  input wire logic ser_fault
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic take;
  logic rd_q;
  logic [1:0] wid_q;
  assign take = ce && req_valid && req_ready;
  // Width is only known at the take, so remember it for the answer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_q <= 1'b0;
      wid_q <= 2'h0;
    end else if (take) begin
      rd_q <= !req.write && !req.commit;
      wid_q <= port_width;
    end
  end
  a_busy_after_take: assert property (take |=> !req_ready || rsp_valid)
    else $error("ready stayed high after a take");
  a_stray_answer: assert property (rsp_valid |-> $past(take) || !$past(req_ready))
    else $error("answer without a request");
  a_read_bound: assert property (take && !req.write && !req.commit |-> ##[1:3] rsp_valid)
    else $error("read answer late");
  a_write_bound: assert property (take && req.write |-> ##[1:17] rsp_valid)
    else $error("write answer late");
  a_commit_bound: assert property (take && req.commit |-> ##[1:9] rsp_valid)
    else $error("commit answer late");
  a_bad_page: assert property (take && req.addr[18:7] >= 12'h840 |=> rsp_valid && rsp.err)
    else $error("page past end not refused");
  a_lock_refuse: assert property (take && prot_all && (req.write || req.commit)
    |=> rsp_valid && rsp.err)
    else $error("locked block accepted a change");
  a_narrow_zero: assert property (rsp_valid && rd_q && !rsp.err
    |-> (wid_q != efb_pkg::WID_X8 || rsp.rdata[31:8] == 24'h0)
    && (wid_q != efb_pkg::WID_X16 || rsp.rdata[31:16] == 16'h0))
    else $error("narrow read not zero-extended");
  a_ser_pulse: assert property (ser_done || ser_fault |=> !ser_done && !ser_fault)
    else $error("serial result pulse too long");
  a_ser_locked: assert property (ser_done |-> !prot_all)
    else $error("serial record written while locked");
  c_commit: cover property (take && req.commit);
  c_refused: cover property (rsp_valid && rsp.err);
  c_ser_fault: cover property (ser_fault);
endmodule : efb_block_sva

bind efb_block efb_block_sva efb_block_sva_i (.core_clk(core_clk), .rst(rst), .ce(ce),
  .port_width(port_width), .req_valid(req_valid), .req(req), .req_ready(req_ready),
  .rsp_valid(rsp_valid), .rsp(rsp), .prot_all(prot_all), .ser_done(ser_done),
  .ser_fault(ser_fault));

//--- verif/efb_host_model.sv
// Fabric-side requester on the parallel port
module efb_host_model (
  input wire logic core_clk,
  output logic req_valid,
  output efb_pkg::efb_req_s req,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire efb_pkg::efb_rsp_s rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    req_valid = 1'b0;
    req = '0;
  end
  // Callers hand in addresses inside page-aligned partitions, apart from the past-the-end page that t_range sends
  task automatic xfer(input efb_pkg::efb_req_s r, output efb_pkg::efb_rsp_s rs,
                      output int lat);
    int n;
    n = 0;
    // One edge between transfers, so valid is never lowered and raised in one step
    @(posedge core_clk);
    #1 req = r;
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      #1 n++;
    end
    @(posedge core_clk);
    #1 req_valid = 1'b0;
    // Released bus shows the inverse, never a stale request
    req = ~r;
    lat = 0;
    while (rsp_valid !== 1'b1 && lat < 40) begin
      @(posedge core_clk);
      #1 lat++;
    end
    rs = rsp;
  endtask : xfer
endmodule : efb_host_model

//--- verif/tb_top.sv
// Self-checking bench for one flash block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Key value is arbitrary
  localparam logic [127:0] KEY = 128'h3C5A_9617_E2D4_0B8F_71C6_A3E9_5D28_F04B;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [1:0] port_width = 2'h0;
  logic prot_all = 1'b0;
  logic [63:0] prot_sector = 64'h0;
  logic sp_sel = 1'b0;
  logic sp_sclk = 1'b0;
  logic sp_sdi = 1'b0;
  logic req_valid, req_ready, rsp_valid, ser_done, ser_fault;
  efb_pkg::efb_req_s req;
  efb_pkg::efb_rsp_s rsp;
  int failures = 0;
  int checked = 0;
  int n_done = 0;
  int n_flt = 0;

  always #20 core_clk = ~core_clk;
  always @(negedge core_clk) begin
    if (ser_done === 1'b1) n_done++;
    if (ser_fault === 1'b1) n_flt++;
  end

  efb_block #(.DECRYPT_KEY(KEY)) efb_block_i (.core_clk(core_clk), .rst(rst), .ce(ce),
    .port_width(port_width), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp(rsp), .prot_all(prot_all), .prot_sector(prot_sector),
    .sp_sel(sp_sel), .sp_sclk(sp_sclk), .sp_sdi(sp_sdi), .ser_done(ser_done),
    .ser_fault(ser_fault));
  efb_host_model efb_host_model_i (.core_clk(core_clk), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp));

  task automatic conclude;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  task automatic cmp_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_val

  // Byte k of data block b holds this pattern once programmed
  function automatic logic [7:0] pb(input logic [14:0] b, input int k);
    return {b[3:0], 4'(k)};
  endfunction : pb

  function automatic logic [18:0] ad(input int b, input int o);
    return 19'h00080 + 19'(b * 16 + o);
  endfunction : ad

  function automatic logic [31:0] ew(input logic [18:0] a, input int n);
    logic [31:0] r;
    r = 32'h0;
    for (int j = 0; j < n; j++) r[8*j +: 8] = pb(a[18:4], int'(a[3:0]) + j);
    return r;
  endfunction : ew

  task automatic ser_rec(input logic [14:0] b, input logic ok);
    logic [143:0] v;
    int d, f, n;
    v[143:128] = {1'b0, b};
    for (int k = 0; k < 16; k++) v[127-8*k -: 8] = pb(b, k) ^ KEY[8*k +: 8];
    d = n_done;
    f = n_flt;
    sp_sel = 1'b1;
    for (int i = 143; i >= 0; i--) begin
      sp_sdi = v[i];
      repeat (4) @(posedge core_clk);
      #1 sp_sclk = 1'b1;
      repeat (4) @(posedge core_clk);
      #1 sp_sclk = 1'b0;
    end
    n = 0;
    while (n_done == d && n_flt == f && n < 40) begin
      @(posedge core_clk);
      #1 n++;
    end
    sp_sel = 1'b0;
    cmp_val("ser_done count", 32'(d + int'(ok)), 32'(n_done));
    cmp_val("ser_fault count", 32'(f + int'(!ok)), 32'(n_flt));
    // Hold select low long enough to pass the pin filter
    repeat (4) @(posedge core_clk);
    #1;
  endtask : ser_rec

  task automatic chk(input logic w, input logic c, input logic [1:0] wid,
                     input logic [18:0] a, input logic [31:0] wd, input logic [31:0] ed,
                     input logic ee, input int el);
    efb_pkg::efb_rsp_s rs;
    int lat;
    port_width = wid;
    efb_host_model_i.xfer({w, c, a, wd}, rs, lat);
    cmp_val("err", {31'h0, ee}, {31'h0, rs.err});
    cmp_val("corr", 32'h0, {31'h0, rs.corr});
    if (!w && !c && !ee) cmp_val("rdata", ed, rs.rdata);
    if (el >= 0) cmp_val("latency", 32'(el), 32'(lat));
  endtask : chk

  task automatic t_program;
    for (int b = 8; b < 16; b++) ser_rec(15'(b), 1'b1);
  endtask : t_program

  task automatic t_reads;
    chk(0, 0, efb_pkg::WID_X32, ad(0, 0), 0, ew(ad(0, 0), 4), 0, 2);
    chk(0, 0, efb_pkg::WID_X32, ad(0, 4), 0, ew(ad(0, 4), 4), 0, 1);
    chk(0, 0, efb_pkg::WID_X8, ad(0, 5), 0, ew(ad(0, 5), 1), 0, 1);
    chk(0, 0, efb_pkg::WID_X16, ad(0, 6), 0, ew(ad(0, 6), 2), 0, 1);
    chk(0, 0, 2'h3, ad(1, 12), 0, ew(ad(1, 12), 4), 0, 2);
  endtask : t_reads

  task automatic t_page_write;
    chk(1, 0, efb_pkg::WID_X8, ad(1, 3), 32'h5A, 0, 0, 16);
    chk(1, 0, efb_pkg::WID_X16, ad(2, 2), 32'hBEEF, 0, 0, 0);
    chk(1, 0, efb_pkg::WID_X8, 19'h00100, 32'h11, 0, 1, 0);
    chk(0, 1, efb_pkg::WID_X32, ad(0, 0), 0, 0, 0, 8);
    chk(0, 0, efb_pkg::WID_X32, ad(2, 0), 0,
        (ew(ad(2, 0), 4) & 32'h0000FFFF) | 32'hBEEF0000, 0, 2);
    chk(0, 0, efb_pkg::WID_X32, ad(1, 0), 0,
        (ew(ad(1, 0), 4) & 32'h00FFFFFF) | 32'h5A000000, 0, 2);
  endtask : t_page_write

  task automatic t_protect;
    // Leave an unsaved edit so the locked commit below has something to refuse
    chk(1, 0, efb_pkg::WID_X8, ad(0, 0), 32'h77, 0, 0, 0);
    prot_sector = 64'h1;
    chk(1, 0, efb_pkg::WID_X8, ad(0, 0), 32'h77, 0, 1, 0);
    chk(0, 1, efb_pkg::WID_X32, ad(0, 0), 0, 0, 1, 0);
    chk(0, 0, efb_pkg::WID_X32, ad(3, 0), 0, ew(ad(3, 0), 4), 0, 2);
    prot_sector = 64'h0;
    prot_all = 1'b1;
    chk(1, 0, efb_pkg::WID_X8, ad(4, 0), 32'h77, 0, 1, 0);
    ser_rec(15'h0008, 1'b0);
    prot_all = 1'b0;
  endtask : t_protect

  task automatic t_range;
    chk(0, 0, efb_pkg::WID_X32, {12'h840, 7'h00}, 0, 0, 1, 0);
    ser_rec(15'h4200, 1'b0);
  endtask : t_range

  initial begin
    // Serial records dominate the run time
    #2000000;
    failures++;
    conclude();
  end

  initial begin
    repeat (8) @(posedge core_clk);
    #1 rst = 1'b0;
    @(posedge core_clk);
    #1;
    t_program();
    t_reads();
    t_page_write();
    t_protect();
    t_range();
    conclude();
  end
endmodule : tb_top
